/* File: rtl/fcf_top.sv */
/*
  Fully-closed feedback configuration: holds restart-applied and live settings,
  steers pulse phase order and overtravel selection, counts external encoder
  feedback and raises the motor-load deviation alarm.
  Assumes encoder quadrature and overtravel pins are asynchronous and that
  positions arrive already synchronous to i_clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fcf_consts.svh"

module fcf_top (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_restart,
  input wire fcf_pkg::fcf_restart_cfg_t i_restart_cfg,
  input wire fcf_pkg::fcf_live_cfg_t i_live_cfg,
  input wire logic i_live_we,
  input wire logic i_fwd_ref,
  input wire logic i_rev_ref,
  input wire logic i_forward_overtravel_input,
  input wire logic i_reverse_overtravel_input,
  input wire logic i_ext_a,
  input wire logic i_ext_b,
  input wire logic i_ext_is_absolute,
  input wire logic [`FCF_POS_W-1:0] i_motor_pos,
  input wire logic [`FCF_POS_W-1:0] i_ext_pos,
  input wire logic [15:0] i_motor_speed,
  input wire logic [15:0] i_ext_speed,
  input wire logic i_alarm_clear,
  output logic o_pulse_output_phase_a,
  output logic o_pulse_output_phase_b,
  output logic o_overtravel_stop,
  output logic [`FCF_POS_W-1:0] o_fully_closed_feedback_counter,
  output logic o_motor_load_overflow_alarm,
  output logic [15:0] o_speed_feedback,
  output logic o_closed_loop_type_indication,
  output logic o_ext_absolute_mode,
  output fcf_pkg::fcf_restart_cfg_t o_active_restart_cfg,
  output fcf_pkg::fcf_live_cfg_t o_active_live_cfg,
  output logic o_cfg_reject
);

  fcf_pkg::fcf_restart_cfg_t act_q;
  fcf_pkg::fcf_live_cfg_t live_q;
  logic rej_q;
  logic rst_ok;
  logic live_ok;
  logic [2:0] a_sync_q;
  logic [2:0] b_sync_q;
  logic [2:0] pot_sync_q;
  logic [2:0] not_sync_q;
  logic a_st_q;
  logic b_st_q;
  logic pot_q;
  logic not_q;
  logic [1:0] qstep_q;
  logic [1:0] phase_q;
  logic [`FCF_POS_W-1:0] cnt_q;
  logic alarm_q;
  logic [`FCF_POS_W-1:0] diff;
  logic [`FCF_POS_W-1:0] mag;
  logic step_en;
  logic step_up;
  logic fwd_step;
  logic [1:0] qnow;
  logic [1:0] qold;

  ////////////////////////////////////////////////////////////////////////////
  // Range checks. Out-of-range or reserved codes are refused whole so that a
  // half-applied setting can never reach the control loop.
  always_comb begin
    rst_ok = (i_restart_cfg.ext_usage == `FCF_USE_NONE) || (i_restart_cfg.ext_usage == `FCF_USE_STD)
      || (i_restart_cfg.ext_usage == `FCF_USE_REV);
    rst_ok = rst_ok && (i_restart_cfg.pitch >= `FCF_PITCH_MIN) && (i_restart_cfg.pitch <= `FCF_PITCH_MAX);
    rst_ok = rst_ok && (i_restart_cfg.motor_type <= `FCF_MTYPE_MAX)
      && (i_restart_cfg.enc_type <= `FCF_ENC_MAX);
    live_ok = (i_live_cfg.threshold <= `FCF_THR_MAX) && (i_live_cfg.multiplier <= `FCF_MULT_MAX);
    live_ok = live_ok && (i_live_cfg.mon1 <= `FCF_MON_MAX) && (i_live_cfg.mon2 <= `FCF_MON_MAX);
  end

  // Restart-class settings are captured only on the restart strobe.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      act_q <= '{rot_dir: `FCF_DIR_RST, abs_as_inc: `FCF_ABS_RST, ext_usage: `FCF_USE_RST,
                 pitch: `FCF_PITCH_RST, spd_src: `FCF_SPD_RST, motor_type: 3'h0,
                 winding: 1'h0, enc_type: 2'h0};
    end else if (i_restart && rst_ok) begin
      act_q <= i_restart_cfg;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      live_q <= '{threshold: `FCF_THR_RST, multiplier: `FCF_MULT_RST,
                  mon1: `FCF_MON1_RST, mon2: `FCF_MON2_RST};
    end else if (i_live_we && live_ok) begin
      live_q <= i_live_cfg;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rej_q <= 1'h0;
    end else begin
      rej_q <= (i_restart && !rst_ok) || (i_live_we && !live_ok);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a level is accepted once stages two and three agree.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      a_sync_q <= 3'h0;
      b_sync_q <= 3'h0;
      pot_sync_q <= 3'h0;
      not_sync_q <= 3'h0;
      a_st_q <= 1'h0;
      b_st_q <= 1'h0;
      pot_q <= 1'h0;
      not_q <= 1'h0;
    end else begin
      a_sync_q <= {a_sync_q[1:0], i_ext_a};
      b_sync_q <= {b_sync_q[1:0], i_ext_b};
      pot_sync_q <= {pot_sync_q[1:0], i_forward_overtravel_input};
      not_sync_q <= {not_sync_q[1:0], i_reverse_overtravel_input};
      if (a_sync_q[1] == a_sync_q[2]) a_st_q <= a_sync_q[2];
      if (b_sync_q[1] == b_sync_q[2]) b_st_q <= b_sync_q[2];
      if (pot_sync_q[1] == pot_sync_q[2]) pot_q <= pot_sync_q[2];
      if (not_sync_q[1] == not_sync_q[2]) not_q <= not_sync_q[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Quadrature decode of the external scale. With usage 1 the cosine-leading
  // sequence counts up; usage 3 flips the sense so CCW again counts up.
  always_comb begin
    qnow = {a_st_q, b_st_q};
    qold = qstep_q;
    step_en = (qnow != qold) && (qnow != ~qold);
    step_up = ({qold[0], ~qold[1]} == qnow);
    if (act_q.ext_usage == `FCF_USE_REV) step_up = !step_up;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      qstep_q <= 2'h0;
      cnt_q <= '0;
    end else begin
      qstep_q <= qnow;
      if (step_en && act_q.ext_usage != `FCF_USE_NONE) begin
        cnt_q <= step_up ? cnt_q + 1'b1 : cnt_q - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divided pulse output. A forward reference walks the phase so that B leads,
  // a reverse one so that A leads, whatever the rotation direction bit says.
  always_comb begin
    fwd_step = i_fwd_ref && !i_rev_ref;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      phase_q <= 2'h0;
    end else if (fwd_step) begin
      phase_q <= phase_q + 2'h1;
    end else if (i_rev_ref && !i_fwd_ref) begin
      phase_q <= phase_q - 2'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_pulse_output_phase_a <= 1'h0;
      o_pulse_output_phase_b <= 1'h0;
      o_overtravel_stop <= 1'h0;
    end else begin
      o_pulse_output_phase_b <= phase_q[1] ^ phase_q[0];
      o_pulse_output_phase_a <= phase_q[1];
      o_overtravel_stop <= (fwd_step && pot_q) || (i_rev_ref && !i_fwd_ref && not_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Motor-load deviation alarm. Sticky until cleared; a new excess in the
  // clearing cycle keeps it set.
  always_comb begin
    diff = i_motor_pos - i_ext_pos;
    mag = diff[`FCF_POS_W-1] ? (~diff + 1'b1) : diff;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      alarm_q <= 1'h0;
    end else if ((live_q.threshold != '0) && (act_q.ext_usage != `FCF_USE_NONE)
                 && (mag > {1'b0, live_q.threshold})) begin
      alarm_q <= 1'h1;
    end else if (i_alarm_clear) begin
      alarm_q <= 1'h0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_speed_feedback <= '0;
      o_closed_loop_type_indication <= 1'h0;
      o_ext_absolute_mode <= 1'h0;
      o_fully_closed_feedback_counter <= '0;
      o_motor_load_overflow_alarm <= 1'h0;
      o_active_restart_cfg <= '0;
      o_active_live_cfg <= '0;
      o_cfg_reject <= 1'h0;
    end else begin
      o_speed_feedback <= act_q.spd_src ? i_ext_speed : i_motor_speed;
      o_closed_loop_type_indication <= (act_q.ext_usage != `FCF_USE_NONE);
      o_ext_absolute_mode <= i_ext_is_absolute;
      o_fully_closed_feedback_counter <= cnt_q;
      o_motor_load_overflow_alarm <= alarm_q;
      o_active_restart_cfg <= act_q;
      o_active_live_cfg <= live_q;
      o_cfg_reject <= rej_q;
    end
  end

endmodule : fcf_top
`default_nettype wire

/* File: rtl/fcf_consts.svh */
/*
  Constants for the fully-closed feedback configuration block: field widths,
  reset values, legal ranges and code points.
  Assumes it is included by its bare name from the package and the top module.
*/
`ifndef FCF_CONSTS_SVH
`define FCF_CONSTS_SVH

`define FCF_DIR_CCW_FWD 1'h0
`define FCF_DIR_CW_FWD 1'h1
`define FCF_DIR_RST 1'h0

`define FCF_USE_NONE 3'h0
`define FCF_USE_STD 3'h1
`define FCF_USE_REV 3'h3
`define FCF_USE_RST 3'h0

`define FCF_ABS_RST 1'h0

`define FCF_PITCH_W 21
`define FCF_PITCH_MIN 21'h000004
`define FCF_PITCH_MAX 21'h100000
`define FCF_PITCH_RST 21'h008000

`define FCF_THR_W 31
`define FCF_THR_MAX 31'h40000000
`define FCF_THR_RST 31'h000003e8

`define FCF_MULT_MAX 7'h64
`define FCF_MULT_RST 7'h14

`define FCF_SPD_RST 1'h0

`define FCF_MTYPE_MAX 3'h5
`define FCF_ENC_MAX 2'h2

`define FCF_MON_MAX 16'h005f
`define FCF_MON1_RST 16'h0002
`define FCF_MON2_RST 16'h0000

`define FCF_POS_W 32

`endif

/* File: rtl/fcf_pkg.sv */
/*
  Types for the fully-closed feedback configuration block.
  Assumes fcf_consts.svh is on the include path.
*/
`include "fcf_consts.svh"

package fcf_pkg;

  typedef struct packed {
    logic rot_dir;
    logic abs_as_inc;
    logic [2:0] ext_usage;
    logic [`FCF_PITCH_W-1:0] pitch;
    logic spd_src;
    logic [2:0] motor_type;
    logic winding;
    logic [1:0] enc_type;
  } fcf_restart_cfg_t;

  typedef struct packed {
    logic [`FCF_THR_W-1:0] threshold;
    logic [6:0] multiplier;
    logic [15:0] mon1;
    logic [15:0] mon2;
  } fcf_live_cfg_t;

  typedef enum logic [1:0] {
    FCF_DEC_SEMI = 2'h0,
    FCF_DEC_STD = 2'h1,
    FCF_DEC_REV = 2'h3
  } fcf_usage_t;

endpackage : fcf_pkg

/* File: tb/fcf_top_properties.sv */
/*
  Port checker for the fully-closed feedback configuration block.
  Assumes it is bound to fcf_top and sees only that module's ports.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fcf_consts.svh"
module fcf_top_chk (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_restart,
  input wire fcf_pkg::fcf_restart_cfg_t i_restart_cfg,
  input wire fcf_pkg::fcf_live_cfg_t i_live_cfg,
  input wire logic i_live_we,
  input wire logic i_fwd_ref,
  input wire logic i_rev_ref,
  input wire logic i_forward_overtravel_input,
  input wire logic i_reverse_overtravel_input,
  input wire logic [15:0] i_motor_speed,
  input wire logic o_pulse_output_phase_a,
  input wire logic o_pulse_output_phase_b,
  input wire logic o_overtravel_stop,
  input wire logic o_motor_load_overflow_alarm,
  input wire logic [15:0] o_speed_feedback,
  input wire fcf_pkg::fcf_restart_cfg_t o_active_restart_cfg,
  input wire fcf_pkg::fcf_live_cfg_t o_active_live_cfg,
  input wire logic o_cfg_reject
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_mult_rej;
    i_live_we && i_live_cfg.multiplier > `FCF_MULT_MAX |-> ##2 o_cfg_reject;
  endproperty
  a_mult_rej: assert property (p_mult_rej)
    else $error("multiplier above range not refused");
  property p_live_take;
    i_live_we && i_live_cfg.threshold <= `FCF_THR_MAX && i_live_cfg.multiplier <= `FCF_MULT_MAX
      && i_live_cfg.mon1 <= `FCF_MON_MAX && i_live_cfg.mon2 <= `FCF_MON_MAX
      |-> ##2 o_active_live_cfg == $past(i_live_cfg, 2);
  endproperty
  a_live_take: assert property (p_live_take)
    else $error("legal live settings not applied");
  property p_pitch_rej;
    i_restart && i_restart_cfg.pitch < `FCF_PITCH_MIN |-> ##2 o_cfg_reject;
  endproperty
  a_pitch_rej: assert property (p_pitch_rej)
    else $error("short pitch not refused");
  property p_use_rej;
    i_restart && i_restart_cfg.ext_usage == 3'h2 |-> ##2 o_cfg_reject;
  endproperty
  a_use_rej: assert property (p_use_rej)
    else $error("reserved usage code not refused");
  property p_spd_sel;
    (!o_active_restart_cfg.spd_src && $stable(i_motor_speed))[*3] |-> o_speed_feedback == i_motor_speed;
  endproperty
  a_spd_sel: assert property (p_spd_sel)
    else $error("motor speed not selected");
  // Six samples: three synchroniser stages, the agreement stage, the output flop and the sample that reads it.
  property p_ot_fwd;
    (i_fwd_ref && !i_rev_ref && i_forward_overtravel_input)[*6] |-> o_overtravel_stop;
  endproperty
  a_ot_fwd: assert property (p_ot_fwd)
    else $error("forward overtravel ignored");
  property p_ot_rev;
    (i_rev_ref && !i_fwd_ref && !i_reverse_overtravel_input)[*6] |-> !o_overtravel_stop;
  endproperty
  a_ot_rev: assert property (p_ot_rev)
    else $error("wrong overtravel input used in reverse");
  property p_b_lead;
    $rose(o_pulse_output_phase_b) && $past(i_fwd_ref) && $past(i_fwd_ref, 2) && !$past(i_rev_ref)
      && !$past(i_rev_ref, 2) |-> !o_pulse_output_phase_a;
  endproperty
  a_b_lead: assert property (p_b_lead)
    else $error("phase B not leading");
  property p_alarm_off;
    $rose(o_motor_load_overflow_alarm) |-> $past(o_active_live_cfg.threshold) != 31'h0;
  endproperty
  a_alarm_off: assert property (p_alarm_off)
    else $error("alarm raised with zero threshold");
endmodule : fcf_top_chk
bind fcf_top fcf_top_chk u_chk (.*);
`default_nettype wire

/* File: tb/fcf_scale_model.sv */
/*
  Behavioural external scale: one quadrature step per request.
  Assumes requests are raised away from the rising clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module fcf_scale_model (
  input wire logic i_clk,
  input wire logic i_step,
  input wire logic i_cos_lead,
  output logic o_a,
  output logic o_b
);
  logic [1:0] ph_q = 2'h0;
  // Gray walk 00,01,11,10 is cosine leading; walking back is sine leading.
  always @(posedge i_clk) if (i_step) ph_q <= i_cos_lead ? ph_q + 2'h1 : ph_q - 2'h1;
  assign o_a = ph_q[1];
  assign o_b = ph_q[1] ^ ph_q[0];
endmodule : fcf_scale_model
`default_nettype wire

/* File: tb/fully_closed_feedback_config_tb.sv */
/*
  Self-checking bench for fcf_top with a behavioural scale.
  Assumes the checker is bound from its own file.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fcf_consts.svh"
module fully_closed_feedback_config_tb;
  logic clk = 1'h0, rst_n = 1'h0, rs = 1'h0, lw = 1'h0, fwd = 1'h0, rev = 1'h0, otf = 1'h0, otr = 1'h0;
  logic isabs = 1'h0, aclr = 1'h0, step = 1'h0, cos = 1'h1, ea, eb, pa, pb, ots, alarm, ind, absm, rej;
  logic [31:0] mpos = 32'h0, epos = 32'h0, cnt, c0;
  logic [15:0] ms = 16'h1234, es = 16'h5678, spd;
  fcf_pkg::fcf_restart_cfg_t rc = '0, good = '{1'h1, 1'h1, 3'h1, 21'h4, 1'h1, 3'h5, 1'h1, 2'h2}, arc;
  fcf_pkg::fcf_live_cfg_t lc = '{`FCF_THR_MAX, 7'h64, 16'h005f, 16'h0000}, alc;
  int failures = 0, total_checks = 0, k;
  // Expected {A, B} pulse codes per cycle: B leads going forward, A leads in reverse.
  logic [1:0] fwd_seq [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  logic [1:0] rev_seq [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
  fcf_scale_model scale (.i_clk(clk), .i_step(step), .i_cos_lead(cos), .o_a(ea), .o_b(eb));
  fcf_top uut (.i_clk(clk), .i_rst_n(rst_n), .i_restart(rs), .i_restart_cfg(rc), .i_live_cfg(lc),
    .i_live_we(lw), .i_fwd_ref(fwd), .i_rev_ref(rev), .i_forward_overtravel_input(otf),
    .i_reverse_overtravel_input(otr), .i_ext_a(ea), .i_ext_b(eb), .i_ext_is_absolute(isabs),
    .i_motor_pos(mpos), .i_ext_pos(epos), .i_motor_speed(ms), .i_ext_speed(es), .i_alarm_clear(aclr),
    .o_pulse_output_phase_a(pa), .o_pulse_output_phase_b(pb), .o_overtravel_stop(ots),
    .o_fully_closed_feedback_counter(cnt), .o_motor_load_overflow_alarm(alarm), .o_speed_feedback(spd),
    .o_closed_loop_type_indication(ind), .o_ext_absolute_mode(absm), .o_active_restart_cfg(arc),
    .o_active_live_cfg(alc), .o_cfg_reject(rej));
  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task tick(input int n); repeat (n) @(negedge clk); endtask : tick
  task chk(input logic [79:0] seen, input logic [79:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task summarize;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  // Settings land two edges after the pulse; the task returns once they are visible.
  task put(input logic live);
    if (live) lw = 1'h1; else rs = 1'h1;
    tick(1);
    lw = 1'h0;
    rs = 1'h0;
    tick(1);
  endtask : put
  task steps(input logic dir);
    cos = dir;
    c0 = cnt;
    repeat (8) begin
      step = 1'h1; tick(1); step = 1'h0; tick(12);
    end
  endtask : steps
  ////////////////////////////////////////////////////////////////////////////////
  initial begin #100000; failures++; summarize(); end
  initial begin
    tick(5); rst_n = 1'h1; tick(3);
    chk(arc.pitch, `FCF_PITCH_RST);
    chk(alc, {`FCF_THR_RST, `FCF_MULT_RST, `FCF_MON1_RST, `FCF_MON2_RST});
    chk({arc.rot_dir, arc.abs_as_inc, arc.spd_src, arc.ext_usage, arc.motor_type, arc.winding, arc.enc_type},
      12'h0);
    chk({spd, ind}, {ms, 1'h0});
    put(1); chk(alc, lc);
    lc.multiplier = 7'h65; put(1); chk({rej, alc.multiplier}, {1'h1, 7'h64});
    lc.multiplier = 7'h64; lc.mon1 = 16'h0060; put(1); chk({rej, alc.mon1}, {1'h1, 16'h005f});
    for (k = 0; k < 6; k++) begin
      rc = good;
      case (k)
        0: rc.ext_usage = 3'h2;
        1: rc.ext_usage = 3'h4;
        2: rc.pitch = 21'h3;
        3: rc.pitch = 21'h100001;
        4: rc.motor_type = 3'h6;
        default: rc.enc_type = 2'h3;
      endcase
      put(0); chk({rej, arc.pitch}, {1'h1, `FCF_PITCH_RST});
    end
    rc = good; put(0); chk(arc, good);
    isabs = 1'h1; tick(3); chk({spd, ind, absm}, {es, 2'h3});
    rc.rot_dir = 1'h0; rc.pitch = 21'h100000; put(0); steps(1); tick(8); chk(cnt, 32'(c0 + 32'h8));
    rc.ext_usage = 3'h3; put(0); steps(1); tick(8); chk(cnt, 32'(c0 - 32'h8));
    rc.ext_usage = 3'h0; put(0); steps(0); tick(8); chk({cnt, ind}, {c0, 1'h0});
    fwd = 1'h1; otf = 1'h1;
    for (k = 0; k < 8; k++) begin
      tick(1);
      chk({pa, pb}, fwd_seq[k % 4]);
    end
    chk(ots, 1'h1);
    fwd = 1'h0; rev = 1'h1;
    for (k = 0; k < 8; k++) begin
      tick(1);
      chk({pa, pb}, rev_seq[k % 4]);
    end
    chk(ots, 1'h0);
    otr = 1'h1; tick(8); chk(ots, 1'h1);
    rev = 1'h0;
    rc.ext_usage = 3'h1; put(0); lc = '{31'h0, 7'h14, 16'h2, 16'h0}; put(1);
    mpos = 32'h100; tick(12); chk(alarm, 1'h0);
    lc.threshold = 31'h5; put(1);
    for (k = 0; k < 20 && alarm !== 1'h1; k++) tick(1);
    if (k == 20) failures++;
    chk(alarm, 1'h1);
    // A clear that meets a standing excess must lose; once the excess is gone it wins.
    aclr = 1'h1; tick(1); aclr = 1'h0; tick(2); chk(alarm, 1'h1);
    mpos = 32'h0; aclr = 1'h1; tick(1); aclr = 1'h0; tick(1); chk(alarm, 1'h0);
    summarize();
  end
endmodule : fully_closed_feedback_config_tb
`default_nettype wire
